/* hw/token_bus_media_pulse_codec.sv */
`timescale 1ns/1ps
// Contract
// R1 - hybrid one: two 100 ns non-overlapping low pulses
// R2 - hybrid zero: both pulse outputs idle
// R3 - hybrid mode only at 2.5 Mbps
// R4 - hybrid receive: positive pulse means one
// R5 - receive expects pulses on 400 ns grid
// R6 - tolerate 100 ns displacement, output NRZ
// R7 - drive style selects push-pull/open-drain, open-drain default
// R8 - backplane one: single 200 ns low pulse
// R9 - backplane receive: negative pulse means one
// R10 - backplane secondary output carries bit clock
// R11 - differential: pulses only while enable asserted
// R12 - reset: transmitter off, outputs inactive
// R13 - grounded strap selects active-high enable
// R14 - strap sampled at reset, backplane only
// R15 - config bit selects backplane encoding
// R16 - timing derived from internal bit clock
module token_bus_media_pulse_codec
    import pulse_codec_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic backplane_select,
    input wire logic drive_style_select,
    input wire logic tx_request,
    input wire logic tx_data,
    output logic tx_bit_taken,
    output logic tx_pulse_primary_n,
    output logic tx_pulse_primary_oe,
    output logic tx_pulse_secondary_n,
    output logic tx_pulse_secondary_oe,
    input wire logic tx_pulse_secondary_in,
    output logic line_driver_enable_out,
    input wire logic rx_line_in,
    output logic rx_data,
    output logic rx_valid
);
    import pulse_codec_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic rx_s1_reg, rx_s2_reg, rx_prev_reg, strap_s1_reg, strap_s2_reg;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1_reg <= 1'b0;
            rx_s2_reg <= 1'b0;
            rx_prev_reg <= 1'b0;
            strap_s1_reg <= 1'b1;
            strap_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rx_line_in;
            rx_s2_reg <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
            strap_s1_reg <= tx_pulse_secondary_in;
            strap_s2_reg <= strap_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap capture once after reset release
    logic strap_done_reg, strap_done_next, enable_high_reg, enable_high_next;
    logic [1:0] strap_wait_reg, strap_wait_next;
    always_comb begin
        strap_done_next = strap_done_reg;
        enable_high_next = enable_high_reg;
        strap_wait_next = strap_wait_reg;
        // wait until the synchroniser holds the pin, not its reset value
        if (!strap_done_reg && strap_wait_reg != 2'h2) begin
            strap_wait_next = strap_wait_reg + 2'h1;
        end else if (!strap_done_reg) begin
            strap_done_next = 1'b1;
            enable_high_next = !strap_s2_reg; // R13 R14
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_done_reg <= 1'b0;
            enable_high_reg <= 1'b0;
            strap_wait_reg <= 2'h0;
        end else begin
            strap_done_reg <= strap_done_next;
            enable_high_reg <= enable_high_next;
            strap_wait_reg <= strap_wait_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit bit timing
    typedef enum logic [1:0] {TX_IDLE, TX_BIT} tx_state_t;
    tx_state_t tx_state_reg, tx_state_next;
    logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
    logic tx_bit_reg, tx_bit_next, taken_next;
    logic p1_next, p2_next, oe1_next, oe2_next, en_next;
    logic mode_bkp;
    assign mode_bkp = backplane_select; // R15 R3
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_bit_next = tx_bit_reg;
        taken_next = 1'b0;
        case (tx_state_reg)
            TX_IDLE: begin
                if (tx_request) begin
                    tx_state_next = TX_BIT;
                    tx_cnt_next = '0;
                    tx_bit_next = tx_data;
                    taken_next = 1'b1;
                end
            end
            TX_BIT: begin
                tx_cnt_next = tx_cnt_reg + 8'h01; // R16
                if (tx_cnt_reg == BIT_LAST) begin
                    tx_cnt_next = '0;
                    if (tx_request) begin
                        tx_bit_next = tx_data;
                        taken_next = 1'b1;
                    end else begin
                        tx_state_next = TX_IDLE;
                    end
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
        en_next = (tx_state_next == TX_BIT) && mode_bkp;
        p1_next = 1'b1;
        p2_next = 1'b1;
        oe1_next = 1'b0;
        oe2_next = 1'b0;
        if (tx_state_next == TX_BIT) begin
            if (!mode_bkp) begin
                oe1_next = 1'b1;
                oe2_next = 1'b1;
                if (tx_bit_next && tx_cnt_next < HYB_P2_START)
                    p1_next = 1'b0; // R1 R2
                if (tx_bit_next && tx_cnt_next >= HYB_P2_START && tx_cnt_next < HYB_P2_END)
                    p2_next = 1'b0; // R1 R2
            end else begin
                if (tx_bit_next && tx_cnt_next < BKP_P1_END)
                    p1_next = 1'b0; // R8 R11
                oe1_next = !p1_next || drive_style_select; // R7
                p2_next = tx_cnt_next >= BIT_HALF; // R10
                oe2_next = 1'b1;
            end
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= '0;
            tx_bit_reg <= 1'b0;
            tx_bit_taken <= 1'b0;
            tx_pulse_primary_n <= 1'b1; // R12
            tx_pulse_primary_oe <= 1'b0;
            tx_pulse_secondary_n <= 1'b1;
            tx_pulse_secondary_oe <= 1'b0;
            line_driver_enable_out <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bit_reg <= tx_bit_next;
            tx_bit_taken <= taken_next;
            tx_pulse_primary_n <= p1_next;
            tx_pulse_primary_oe <= oe1_next;
            tx_pulse_secondary_n <= p2_next;
            tx_pulse_secondary_oe <= oe2_next;
            // idle level follows strap polarity, hybrid keeps active low
            line_driver_enable_out <= (mode_bkp && enable_high_reg) ? en_next : !en_next; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive: first pulse of a burst sets a 400 ns bit grid
    logic rx_edge, rx_active_reg, rx_active_next, rx_hit_reg, rx_hit_next;
    logic [CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
    logic rx_data_next, rx_valid_next;
    logic [3:0] rx_idle_reg, rx_idle_next;
    // hybrid pulse rises, backplane pulse falls
    assign rx_edge = mode_bkp ? (rx_prev_reg && !rx_s2_reg)
                              : (!rx_prev_reg && rx_s2_reg); // R4 R9
    always_comb begin
        rx_active_next = rx_active_reg;
        rx_hit_next = rx_hit_reg;
        rx_cnt_next = (rx_cnt_reg == BIT_LAST) ? '0 : rx_cnt_reg + 8'h01;
        rx_idle_next = rx_idle_reg;
        rx_data_next = 1'b0;
        rx_valid_next = 1'b0;
        if (rx_edge && !rx_active_reg) begin
            // next nominal pulse then lands at count BIT_HALF
            rx_active_next = 1'b1;
            rx_hit_next = 1'b1; // R5
            rx_cnt_next = BIT_HALF + 8'h01;
            rx_idle_next = '0;
        end else if (rx_edge && rx_cnt_reg >= BIT_HALF - 8'(RX_TOL_CYC)
                     && rx_cnt_reg <= RX_WIN_END) begin
            // later pulses only mark a hit, so jitter never shifts the grid
            rx_hit_next = 1'b1; // R6
            rx_idle_next = '0;
        end
        if (rx_active_reg && rx_cnt_reg == RX_WIN_END) begin
            rx_valid_next = 1'b1; // R5
            rx_data_next = rx_hit_reg || rx_edge; // R6
            rx_hit_next = 1'b0;
            if (!(rx_hit_reg || rx_edge)) begin
                rx_idle_next = rx_idle_reg + 4'h1;
                if (rx_idle_reg == 4'hF)
                    rx_active_next = 1'b0;
            end
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_active_reg <= 1'b0;
            rx_hit_reg <= 1'b0;
            rx_cnt_reg <= '0;
            rx_idle_reg <= '0;
            rx_data <= 1'b0;
            rx_valid <= 1'b0;
        end else begin
            rx_active_reg <= rx_active_next;
            rx_hit_reg <= rx_hit_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_idle_reg <= rx_idle_next;
            rx_data <= rx_data_next;
            rx_valid <= rx_valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_HYB_ZERO_IDLE: assert property (@(posedge mclk) disable iff (!reset_n) // R2
        (tx_state_reg == TX_BIT && !tx_bit_reg && !mode_bkp)
            |-> tx_pulse_primary_n && tx_pulse_secondary_n)
        else $error("hybrid zero drove a pulse");
    AST_HYB_NO_OVERLAP: assert property (@(posedge mclk) disable iff (!reset_n) // R1
        !(!tx_pulse_primary_n && !tx_pulse_secondary_n && !mode_bkp))
        else $error("hybrid pulses overlap");
    AST_HYB_P1_WIDTH: assert property (@(posedge mclk) disable iff (!reset_n) // R1
        ($fell(tx_pulse_primary_n) && !mode_bkp && $stable(backplane_select))
            |-> !tx_pulse_primary_n[*8] ##1 !tx_pulse_primary_n[*2] ##1 tx_pulse_primary_n)
        else $error("hybrid primary pulse width wrong");
    AST_BKP_P1_WIDTH: assert property (@(posedge mclk) disable iff (!reset_n) // R8
        ($fell(tx_pulse_primary_n) && mode_bkp)
            |-> !tx_pulse_primary_n[*8] ##1 !tx_pulse_primary_n[*8]
                ##1 !tx_pulse_primary_n[*4] ##1 tx_pulse_primary_n)
        else $error("backplane pulse width wrong");
    AST_DIFF_GATED: assert property (@(posedge mclk) disable iff (!reset_n) // R11
        (!tx_pulse_primary_n && mode_bkp)
            |-> (line_driver_enable_out == enable_high_reg))
        else $error("pulse without transmit enable");
    AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (!reset_n) // R7
        (mode_bkp && !drive_style_select && tx_pulse_primary_oe) |-> !tx_pulse_primary_n)
        else $error("open drain drove high");
    AST_RX_GRID: assert property (@(posedge mclk) disable iff (!reset_n) // R5
        rx_valid |-> ##1 !rx_valid[*8])
        else $error("receive bits closer than grid");
    AST_STRAP_ONCE: assert property (@(posedge mclk) disable iff (!reset_n) // R14
        strap_done_reg |=> $stable(enable_high_reg))
        else $error("strap polarity changed");
endmodule // token_bus_media_pulse_codec

/* hw/pulse_codec_pkg.sv */
package pulse_codec_pkg;
    // timing in ns, cycle counts derived from the 100 MHz clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 400;
    localparam int HYB_PULSE_NS = 100;
    localparam int BKP_PULSE_NS = 200;
    localparam int RX_TOL_NS = 100;
    localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int HYB_PULSE_CYC = (HYB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BKP_PULSE_CYC = (BKP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_TOL_CYC = RX_TOL_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // secondary pulse of a hybrid one starts after the primary ends
    localparam logic [CNT_W-1:0] HYB_P2_START = 8'(HYB_PULSE_CYC);
    localparam logic [CNT_W-1:0] HYB_P2_END = 8'(2 * HYB_PULSE_CYC);
    localparam logic [CNT_W-1:0] BKP_P1_END = 8'(BKP_PULSE_CYC);
    localparam logic [CNT_W-1:0] BIT_LAST = 8'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] BIT_HALF = 8'(BIT_CYC / 2);
    localparam logic [CNT_W-1:0] RX_WIN_END = 8'(BIT_CYC / 2 + RX_TOL_CYC);
    localparam logic DRIVE_STYLE_RESET = 1'b0;
endpackage

/* verification/media_line_model.sv */
`timescale 1ns/1ps
module media_line_model (
    input wire logic mclk,
    input wire logic tx_pulse_primary_n,
    input wire logic tx_pulse_primary_oe,
    input wire logic tx_pulse_secondary_n,
    input wire logic tx_pulse_secondary_oe,
    input wire logic strap_ground,
    output logic tx_pulse_secondary_in,
    output logic rx_line_in,
    output logic bus_level
);
    localparam int SH [4] = '{0, 9, 0, -9};
    // pull-up on the shared line
    assign bus_level = (tx_pulse_primary_oe && !tx_pulse_primary_n) ? 1'b0 : 1'b1;
    // grounded strap wins over the driven clock
    assign tx_pulse_secondary_in = strap_ground ? 1'b0 :
        (tx_pulse_secondary_oe ? tx_pulse_secondary_n : 1'b1);
    initial rx_line_in = 1'b0;
    ////////////////////////////////////////
    // one cell per bit, bit 0 first, pulses off grid by up to 90 ns
    task automatic send_cells(input logic active_low, input logic [3:0] bits);
        logic hit;
        for (int c = 0; c < 200; c++) begin
            @(negedge mclk);
            hit = 1'b0;
            for (int i = 0; i < 4; i++) begin
                if (bits[i] && c >= 40 * i + SH[i] + 10 && c < 40 * i + SH[i] + 20) begin
                    hit = 1'b1;
                end
            end
            rx_line_in = hit ^ active_low;
        end
    endtask
endmodule // media_line_model

/* verification/token_bus_media_pulse_codec_test.sv */
`timescale 1ns/1ps
module token_bus_media_pulse_codec_test;
    import pulse_codec_pkg::*;
    logic mclk, reset_n, backplane_select, drive_style_select, tx_request, tx_data;
    logic strap_ground, tx_bit_taken, p_n, p_oe, s_n, s_oe, s_in, en, rx_in, rx_data, rx_valid;
    logic bus_level;
    int n_fail, tests_run;
    token_bus_media_pulse_codec token_bus_media_pulse_codec_inst (.mclk(mclk),
        .reset_n(reset_n), .backplane_select(backplane_select),
        .drive_style_select(drive_style_select), .tx_request(tx_request), .tx_data(tx_data),
        .tx_bit_taken(tx_bit_taken), .tx_pulse_primary_n(p_n), .tx_pulse_primary_oe(p_oe),
        .tx_pulse_secondary_n(s_n), .tx_pulse_secondary_oe(s_oe),
        .tx_pulse_secondary_in(s_in), .line_driver_enable_out(en), .rx_line_in(rx_in),
        .rx_data(rx_data), .rx_valid(rx_valid));
    media_line_model line_model_inst (.mclk(mclk), .tx_pulse_primary_n(p_n),
        .tx_pulse_primary_oe(p_oe), .tx_pulse_secondary_n(s_n), .tx_pulse_secondary_oe(s_oe),
        .strap_ground(strap_ground), .tx_pulse_secondary_in(s_in), .rx_line_in(rx_in),
        .bus_level(bus_level));
    ////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
            n_fail++;
        end
    endtask
    // sends one bit, counts low cycles of each output and first low cycle of the secondary over the cell
    task automatic tx_cell(input logic d, output logic [7:0] pl, sl, sf, ov, oe_n, output logic e0);
        pl = 0; sl = 0; sf = 8'hFF; ov = 0; oe_n = 0;
        @(negedge mclk);
        tx_request = 1'b1;
        tx_data = d;
        @(negedge mclk);
        tx_request = 1'b0;
        check("tx_bit_taken", 8'h01, {7'h0, tx_bit_taken});
        e0 = en;
        for (int k = 0; k < BIT_CYC; k++) begin
            if (p_n === 1'b0) pl++;
            if (s_n === 1'b0 && sf == 8'hFF) sf = 8'(k);
            if (s_n === 1'b0) sl++;
            if (p_n === 1'b0 && s_n === 1'b0) ov++;
            if (p_oe === 1'b1) oe_n++;
            @(negedge mclk);
        end
    endtask
    ////////////////////////////////////////
    task automatic test_hybrid_tx();
        logic [7:0] pl, sl, sf, ov, oe_n;
        logic e0;
        backplane_select = 1'b0;
        tx_cell(1'b1, pl, sl, sf, ov, oe_n, e0);
        check("hyb_primary_low", 8'(HYB_PULSE_CYC), pl);
        check("hyb_secondary_low", 8'(HYB_PULSE_CYC), sl);
        check("hyb_secondary_start", 8'(HYB_PULSE_CYC), sf);
        check("hyb_overlap", 8'h00, ov);
        check("hyb_enable", 8'h01, {7'h0, e0});
        tx_cell(1'b0, pl, sl, sf, ov, oe_n, e0);
        check("hyb_zero_low", 8'h00, pl + sl);
    endtask
    task automatic test_backplane_tx(input logic push_pull);
        logic [7:0] pl, sl, sf, ov, oe_n;
        logic e0;
        backplane_select = 1'b1;
        drive_style_select = push_pull;
        tx_cell(1'b1, pl, sl, sf, ov, oe_n, e0);
        check("bkp_primary_low", 8'(BKP_PULSE_CYC), pl);
        check("bkp_clock_low", 8'(BIT_CYC / 2), sl);
        check("bkp_oe_cycles", push_pull ? 8'(BIT_CYC) : 8'(BKP_PULSE_CYC), oe_n);
        check("bkp_enable_on", 8'h01, {7'h0, e0});
        repeat (3) @(negedge mclk);
        check("bkp_enable_off", 8'h00, {7'h0, en});
        check("bkp_line_released", 8'h01, {7'h0, bus_level});
    endtask
    task automatic test_rx(input logic bkp);
        logic [3:0] got;
        int n;
        backplane_select = bkp;
        got = 4'h0;
        n = 0;
        fork
            line_model_inst.send_cells(bkp, 4'hB);
            for (int c = 0; c < 400 && n < 4; c++) begin
                @(negedge mclk);
                if (rx_valid === 1'b1) begin
                    got[n] = rx_data;
                    n++;
                end
            end
        join
        check("rx_bits", 8'h0B, {4'h0, got});
        repeat (800) @(negedge mclk);
    endtask
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200us;
        n_fail++;
        print_verdict();
    end
    initial begin
        n_fail = 0;
        tests_run = 0;
        reset_n = 1'b0;
        backplane_select = 1'b0;
        drive_style_select = DRIVE_STYLE_RESET;
        tx_request = 1'b0;
        tx_data = 1'b0;
        strap_ground = 1'b1;
        repeat (4) @(negedge mclk);
        check("reset_outputs", 8'h38, {2'h0, p_n, s_n, en, p_oe, s_oe, rx_valid});
        reset_n = 1'b1;
        repeat (6) @(negedge mclk);
        strap_ground = 1'b0;
        test_hybrid_tx();
        test_backplane_tx(1'b0);
        test_backplane_tx(1'b1);
        test_rx(1'b0);
        test_rx(1'b1);
        print_verdict();
    end
endmodule // token_bus_media_pulse_codec_test
